// ---- pcb_regs.sv ----
// latency timer, line size, header type and link window base registers
`timescale 1ns/1ps

module pcb_regs (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire pcb_pkg::pcb_cfg_req_t cfg_req_i,
  output logic                      cfg_ack_o,
  output logic [31:0]               cfg_rdata_o,
  input  wire pcb_pkg::pcb_init_t   init_i,
  output logic                      lat_expired_o,
  output logic                      init_stop_o,
  output logic [7:0]                line_span_words_o,
  input  wire logic                 mem_valid_i,
  input  wire logic [31:0]          mem_addr_i,
  input  wire logic                 mem_space_en_i,
  output logic                      mem_hit_o
);

  logic [7:0]  lat_reg;
  logic [7:0]  line_reg;
  logic [20:0] window_base_bits_reg;
  logic [7:0]  lat_cnt_reg;
  logic [7:0]  lat_cnt_next;
  logic        lat_expired_reg;
  logic        lat_expired_next;
  logic        init_stop_reg;
  logic        init_stop_next;
  logic        cfg_ack_reg;
  logic [31:0] cfg_rdata_reg;
  logic        mem_hit_reg;

  // every check below runs on the one clock and is off during reset
  default clocking chk_cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // access decode
  wire logic        wr_en      = cfg_req_i.valid & cfg_req_i.write;
  wire logic        rd_en      = cfg_req_i.valid & ~cfg_req_i.write;
  wire logic [5:0]  dword_sel  = cfg_req_i.addr[7:2];
  wire logic        sel_lat    = (dword_sel == pcb_pkg::OFS_LAT_LINE[7:2]);
  wire logic        sel_win    = (dword_sel == pcb_pkg::OFS_WIN_BASE[7:2]);
  wire logic        wr_line    = wr_en & sel_lat & cfg_req_i.be[0];
  wire logic        wr_lat     = wr_en & sel_lat & cfg_req_i.be[1];
  wire logic        wr_win_b1  = wr_en & sel_win & cfg_req_i.be[1];
  wire logic        wr_win_b2  = wr_en & sel_win & cfg_req_i.be[2];
  wire logic        wr_win_b3  = wr_en & sel_win & cfg_req_i.be[3];

  // fixed fields; byte lanes 2 and 3 of the 0ch dword have no storage
  wire logic [15:0] hdr_word   = {pcb_pkg::SELF_TEST_VAL,
                                  pcb_pkg::HEADER_VAL};
  wire logic [10:0] win_low    = {pcb_pkg::WIN_SIZE_VAL,
                                  pcb_pkg::WIN_PF_VAL,
                                  pcb_pkg::WIN_TYPE_VAL,
                                  pcb_pkg::WIN_SPACE_VAL};
  wire logic [31:0] word_lat   = {hdr_word, lat_reg, line_reg};
  wire logic [31:0] word_win   = {window_base_bits_reg, win_low};
  // unmapped dwords read as zero
  wire logic [31:0] rdata_next = sel_lat ? word_lat :
                                 sel_win ? word_win : 32'h0000_0000;

  // latency counter; saturates so a long burst cannot wrap and re-arm
  wire logic        cnt_at_max = (lat_cnt_reg == pcb_pkg::LAT_CNT_MAX);
  wire logic        limit_hit  = (lat_cnt_reg >= lat_reg);

  always_comb begin
    lat_cnt_next = lat_cnt_reg;
    if (init_i.frame_start) begin
      lat_cnt_next = pcb_pkg::LAT_CNT_ZERO;
    end else if (init_i.active && !cnt_at_max) begin
      lat_cnt_next = lat_cnt_reg + 8'h01;
    end
  end

  // expiry stays set until the next frame starts or active drops
  assign lat_expired_next = ~init_i.frame_start & init_i.active &
                            (lat_expired_reg | limit_hit);
  // grant removed is gnt_n high
  assign init_stop_next   = ~init_i.frame_start & init_i.active &
                            lat_expired_reg & init_i.gnt_n;

  wire logic win_match = (mem_addr_i[31:pcb_pkg::WIN_BASE_LSB] ==
                          window_base_bits_reg);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_reg  <= pcb_pkg::LAT_RESET;
      line_reg <= pcb_pkg::LINE_RESET;
    end else begin
      if (wr_lat) begin
        lat_reg <= cfg_req_i.wdata[15:8];
      end
      if (wr_line) begin
        line_reg <= cfg_req_i.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      window_base_bits_reg <= pcb_pkg::WIN_BASE_RESET;
    end else begin
      if (wr_win_b1) begin
        window_base_bits_reg[4:0] <= cfg_req_i.wdata[15:11];
      end
      if (wr_win_b2) begin
        window_base_bits_reg[12:5] <= cfg_req_i.wdata[23:16];
      end
      if (wr_win_b3) begin
        window_base_bits_reg[20:13] <= cfg_req_i.wdata[31:24];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_ack_reg   <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_ack_reg <= cfg_req_i.valid;
      if (rd_en) begin
        cfg_rdata_reg <= rdata_next;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_cnt_reg     <= pcb_pkg::LAT_CNT_ZERO;
      lat_expired_reg <= 1'b0;
      init_stop_reg   <= 1'b0;
      mem_hit_reg     <= 1'b0;
    end else begin
      lat_cnt_reg     <= lat_cnt_next;
      lat_expired_reg <= lat_expired_next;
      init_stop_reg   <= init_stop_next;
      mem_hit_reg     <= mem_valid_i & mem_space_en_i & win_match;
    end
  end

  assign cfg_ack_o         = cfg_ack_reg;
  assign cfg_rdata_o       = cfg_rdata_reg;
  assign lat_expired_o     = lat_expired_reg;
  assign init_stop_o       = init_stop_reg;
  assign line_span_words_o = line_reg;
  assign mem_hit_o         = mem_hit_reg;

  // checks
  sequence win_ones_write_s;
    wr_en && sel_win && (cfg_req_i.be == 4'hf) &&
      (cfg_req_i.wdata == 32'hffff_ffff);
  endsequence

  sequence win_read_s;
    rd_en && sel_win && !wr_en;
  endsequence

  sequence lat_limit_s;
    init_i.active && !init_i.frame_start && limit_hit;
  endsequence

  sequence grant_gone_s;
    init_i.active && !init_i.frame_start && init_i.gnt_n;
  endsequence

  lat_write_a: assert property (
    wr_lat |=> (lat_reg == $past(cfg_req_i.wdata[15:8])) &&
      (cfg_rdata_o[15:8] == lat_reg || !$past(rd_en)))
    else $error("latency limit not written");

  cnt_restart_a: assert property (
    init_i.frame_start ##1 (init_i.active && !init_i.frame_start)
      |=> (lat_cnt_reg == 8'h01))
    else $error("latency count did not restart from zero");

  cnt_advance_a: assert property (
    (init_i.active && !init_i.frame_start && !cnt_at_max)
      |=> (lat_cnt_reg == $past(lat_cnt_reg) + 8'h01))
    else $error("latency count did not advance");

  stop_on_gnt_a: assert property (
    (init_i.active && !init_i.frame_start && limit_hit) ##1
      (init_i.active && !init_i.frame_start && init_i.gnt_n)
      |=> init_stop_o)
    else $error("transaction not ended after expiry and grant loss");

  no_early_stop_a: assert property (
    init_stop_o |-> $past(lat_expired_o) && $past(init_i.gnt_n))
    else $error("transaction ended before expiry");

  line_size_a: assert property (
    wr_line |=> (line_span_words_o == $past(cfg_req_i.wdata[7:0])))
    else $error("line size not applied");

  hdr_fixed_a: assert property (
    (rd_en && sel_lat) |=> (cfg_rdata_o[31:16] == 16'h0000))
    else $error("header and self-test not zero");

  win_sizing_a: assert property (
    win_ones_write_s ##1 win_read_s |=> (cfg_rdata_o == 32'hffff_f800))
    else $error("window sizing read back wrong");

  win_low_zero_a: assert property (
    (rd_en && sel_win) |=> (cfg_rdata_o[10:0] == 11'h000))
    else $error("window low bits not zero");

  win_decode_a: assert property (
    (mem_valid_i && mem_space_en_i &&
      (mem_addr_i[31:11] == window_base_bits_reg)) |=> mem_hit_o)
    else $error("window hit missed");

  ack_timing_a: assert property (
    cfg_req_i.valid |=> cfg_ack_o ##0 $past(cfg_req_i.valid))
    else $error("access not answered in one cycle");

  lat_hold_a: assert property (
    !wr_lat |=> $stable(lat_reg))
    else $error("latency limit changed without a write");

  lat_rd_a: assert property (
    (rd_en && sel_lat) |=> (cfg_rdata_o[15:8] == $past(lat_reg)))
    else $error("latency limit read back wrong");

  line_hold_a: assert property (
    !wr_line |=> $stable(line_reg))
    else $error("line size changed without a write");

  line_rd_a: assert property (
    (rd_en && sel_lat) |=> (cfg_rdata_o[7:0] == $past(line_reg)))
    else $error("line size read back wrong");

  cnt_hold_a: assert property (
    (!init_i.frame_start && !init_i.active) |=> $stable(lat_cnt_reg))
    else $error("latency count moved while idle");

  cnt_saturate_a: assert property (
    (cnt_at_max && !init_i.frame_start) |=> cnt_at_max)
    else $error("latency count wrapped past its top");

  expiry_set_a: assert property (
    lat_limit_s |=> lat_expired_o)
    else $error("expiry not flagged at the limit");

  expiry_cause_a: assert property (
    lat_expired_o |-> $past(limit_hit) || $past(lat_expired_o))
    else $error("expiry flagged below the limit");

  expiry_clear_a: assert property (
    (init_i.frame_start || !init_i.active) |=>
      (!lat_expired_o && !init_stop_o))
    else $error("expiry or stop kept outside a transaction");

  stop_needs_gnt_a: assert property (
    !init_i.gnt_n |=> !init_stop_o)
    else $error("transaction ended while grant still held");

  stop_hold_a: assert property (
    lat_limit_s ##1 grant_gone_s ##1 grant_gone_s
      |=> (init_stop_o && lat_expired_o))
    else $error("stop request not held while grant stays away");

  base_rd_a: assert property (
    (rd_en && sel_win) |=>
      (cfg_rdata_o[31:11] == $past(window_base_bits_reg)))
    else $error("window base read back wrong");

  base_b1_a: assert property (
    wr_win_b1 |=>
      (window_base_bits_reg[4:0] == $past(cfg_req_i.wdata[15:11])))
    else $error("window base low bits not written");

  base_b2_a: assert property (
    wr_win_b2 |=>
      (window_base_bits_reg[12:5] == $past(cfg_req_i.wdata[23:16])))
    else $error("window base middle byte not written");

  base_b3_a: assert property (
    wr_win_b3 |=>
      (window_base_bits_reg[20:13] == $past(cfg_req_i.wdata[31:24])))
    else $error("window base top byte not written");

  base_hold_a: assert property (
    !(wr_en && sel_win) |=> $stable(window_base_bits_reg))
    else $error("window base changed without a write");

  miss_decode_a: assert property (
    !(mem_valid_i && mem_space_en_i && win_match) |=> !mem_hit_o)
    else $error("window hit without a matching address");

  unmapped_zero_a: assert property (
    (rd_en && !sel_lat && !sel_win) |=> (cfg_rdata_o == 32'h0000_0000))
    else $error("unmapped dword did not read zero");

  ack_idle_a: assert property (
    !cfg_req_i.valid |=> !cfg_ack_o)
    else $error("answer without a request");

  rdata_hold_a: assert property (
    !rd_en |=> $stable(cfg_rdata_o))
    else $error("read data changed without a read");

endmodule : pcb_regs

// ---- pcb_pkg.sv ----
// shared constants and carrier types for the config header bar registers
package pcb_pkg;

  // config space byte offsets
  localparam logic [7:0]  OFS_LAT_LINE   = 8'h0c;
  localparam logic [7:0]  OFS_HDR_SELF   = 8'h0e;
  localparam logic [7:0]  OFS_WIN_BASE   = 8'h10;

  // values after reset and fixed read values
  localparam logic [7:0]  LAT_RESET      = 8'h00;
  localparam logic [7:0]  LINE_RESET     = 8'h00;
  localparam logic [7:0]  SELF_TEST_VAL  = 8'h00;
  localparam logic [7:0]  HEADER_VAL     = 8'h00;
  localparam logic [20:0] WIN_BASE_RESET = 21'h00_0000;
  localparam logic [6:0]  WIN_SIZE_VAL   = 7'h00;
  localparam logic        WIN_PF_VAL     = 1'b0;
  localparam logic [1:0]  WIN_TYPE_VAL   = 2'h0;
  localparam logic        WIN_SPACE_VAL  = 1'b0;

  // field positions
  localparam int          WIN_BASE_LSB   = 11;
  localparam int          LAT_LSB        = 8;

  // latency counter limits
  localparam logic [7:0]  LAT_CNT_ZERO   = 8'h00;
  localparam logic [7:0]  LAT_CNT_MAX    = 8'hff;

  // one configuration access, byte offset dword aligned
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcb_cfg_req_t;

  // initiator side status from the bus master engine
  typedef struct packed {
    logic frame_start;
    logic active;
    logic gnt_n;
  } pcb_init_t;

endpackage : pcb_pkg

// ---- pcb_regs_dummy_never.sv ----
// holds no logic; the whole register block lives in pcb_regs.sv

// ---- pcb_host_model.sv ----
// host bridge model issuing configuration and memory cycles
`timescale 1ns/1ps

module pcb_host_model (
  input  wire logic                  clock_i,
  output pcb_pkg::pcb_cfg_req_t      cfg_req_o,
  input  wire logic                  cfg_ack_i,
  input  wire logic [31:0]           cfg_rdata_i,
  output logic                       mem_valid_o,
  output logic [31:0]                mem_addr_o,
  output logic                       mem_space_en_o,
  input  wire logic                  mem_hit_i
);
  initial begin
    cfg_req_o      = '0;
    mem_valid_o    = 1'b0;
    mem_addr_o     = 32'h0000_0000;
    mem_space_en_o = 1'b0;
  end

  // one access held a full cycle; released lines carry inverted junk
  task automatic cfg_cycle(input logic wr, input logic [7:0] a,
                           input logic [3:0] be, input logic [31:0] wd,
                           output logic ack, output logic [31:0] rd);
    @(negedge clock_i);
    cfg_req_o = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: wd};
    @(negedge clock_i);
    ack = cfg_ack_i;
    rd = cfg_rdata_i;
    cfg_req_o = '{valid: 1'b0, write: ~wr, addr: ~a, be: ~be, wdata: ~wd};
  endtask : cfg_cycle

  // write then read with no idle cycle between them
  task automatic cfg_wr_rd(input logic [7:0] a, input logic [31:0] wd,
                           output logic wack, output logic rack,
                           output logic [31:0] rd);
    @(negedge clock_i);
    cfg_req_o = '{valid: 1'b1, write: 1'b1, addr: a, be: 4'hf, wdata: wd};
    @(negedge clock_i);
    wack = cfg_ack_i;
    cfg_req_o = '{valid: 1'b1, write: 1'b0, addr: a, be: 4'hf, wdata: ~wd};
    @(negedge clock_i);
    rack = cfg_ack_i;
    rd = cfg_rdata_i;
    cfg_req_o = '{valid: 1'b0, write: 1'b1, addr: ~a, be: 4'h0, wdata: wd};
  endtask : cfg_wr_rd

  // memory address probe; hit is registered so it is read one cycle on
  task automatic mem_probe(input logic [31:0] a, input logic en,
                           output logic hit);
    @(negedge clock_i);
    mem_valid_o = 1'b1;
    mem_addr_o = a;
    mem_space_en_o = en;
    @(negedge clock_i);
    hit = mem_hit_i;
    mem_valid_o = 1'b0;
    mem_addr_o = ~a;
  endtask : mem_probe
endmodule : pcb_host_model

// ---- tb_top.sv ----
// testbench for the config header latency, header and window registers
`timescale 1ns/1ps

module tb_top;
  logic                  clock_i;
  logic                  rst_n_i;
  pcb_pkg::pcb_cfg_req_t cfg_req;
  pcb_pkg::pcb_init_t    init;
  logic                  cfg_ack;
  logic [31:0]           cfg_rdata;
  logic                  lat_expired;
  logic                  init_stop;
  logic [7:0]            line_span;
  logic                  mem_valid;
  logic [31:0]           mem_addr;
  logic                  mem_space_en;
  logic                  mem_hit;
  int                    miscompares;
  int                    checks;

  pcb_regs dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req),
    .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata), .init_i(init),
    .lat_expired_o(lat_expired), .init_stop_o(init_stop),
    .line_span_words_o(line_span), .mem_valid_i(mem_valid),
    .mem_addr_i(mem_addr), .mem_space_en_i(mem_space_en),
    .mem_hit_o(mem_hit));

  pcb_host_model host (.clock_i(clock_i), .cfg_req_o(cfg_req),
    .cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata), .mem_valid_o(mem_valid),
    .mem_addr_o(mem_addr), .mem_space_en_o(mem_space_en),
    .mem_hit_i(mem_hit));

  task automatic finish_test;
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    logic        ack;
    logic [31:0] rd;
    host.cfg_cycle(1'b0, a, 4'hf, 32'h0000_0000, ack, rd);
    check({what, " ack"}, 32'h0000_0001, {31'h0, ack});
    check(what, exp, rd);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    logic        ack;
    logic [31:0] rd;
    host.cfg_cycle(1'b1, a, be, d, ack, rd);
  endtask : wr

  task automatic wr_rd_chk(input string what, input logic [7:0] a,
                           input logic [31:0] d, input logic [31:0] exp);
    logic        wack;
    logic        rack;
    logic [31:0] rd;
    host.cfg_wr_rd(a, d, wack, rack, rd);
    check({what, " acks"}, 32'h0000_0003, {30'h0, wack, rack});
    check(what, exp, rd);
  endtask : wr_rd_chk

  task automatic mem_chk(input logic [31:0] a, input logic en,
                         input logic exp);
    logic hit;
    host.mem_probe(a, en, hit);
    check("window hit", {31'h0, exp}, {31'h0, hit});
  endtask : mem_chk

  // count clocks from frame start to expiry, then watch grant removal
  task automatic lat_run(input logic [7:0] lim);
    int n;
    wr(pcb_pkg::OFS_LAT_LINE, 4'h2, {16'h0, lim, 8'h00});
    @(negedge clock_i);
    init = '{frame_start: 1'b1, active: 1'b1, gnt_n: 1'b0};
    @(negedge clock_i);
    init.frame_start = 1'b0;
    n = 1;
    while (lat_expired !== 1'b1 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    check("expiry clocks", {24'h0, lim} + 32'h0000_0002, n);
    check("stop with grant", 32'h0, {31'h0, init_stop});
    init.gnt_n = 1'b1;
    @(negedge clock_i);
    check("stop no grant", 32'h0000_0001, {31'h0, init_stop});
    @(negedge clock_i);
    check("stop held", 32'h0000_0001, {31'h0, init_stop});
    init = '{frame_start: 1'b0, active: 1'b0, gnt_n: 1'b1};
    @(negedge clock_i);
    check("expired idle", 32'h0, {31'h0, lat_expired});
  endtask : lat_run

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // whole run is well under a thousand clocks
  initial begin
    repeat (5000) @(posedge clock_i);
    miscompares++;
    finish_test();
  end

  initial begin
    rst_n_i = 1'b0;
    init = '0;
    miscompares = 0;
    checks = 0;
    repeat (16) @(negedge clock_i);
    rst_n_i = 1'b1;
    rd_chk("lat line rst", pcb_pkg::OFS_LAT_LINE, 32'h0000_0000);
    rd_chk("base rst", pcb_pkg::OFS_WIN_BASE, 32'h0000_0000);
    wr(pcb_pkg::OFS_LAT_LINE, 4'hf, 32'hffff_ffff);
    rd_chk("lat line ones", pcb_pkg::OFS_LAT_LINE, 32'h0000_ffff);
    check("line span", 32'h0000_00ff, {24'h0, line_span});
    lat_run(8'h00);
    lat_run(8'hff);
    lat_run(8'h03);
    rd_chk("lat line mix", pcb_pkg::OFS_LAT_LINE, 32'h0000_03ff);
    wr(pcb_pkg::OFS_WIN_BASE, 4'hf, 32'hffff_ffff);
    rd_chk("base size", pcb_pkg::OFS_WIN_BASE, 32'hffff_f800);
    wr(pcb_pkg::OFS_WIN_BASE, 4'hf, 32'h1234_5fff);
    rd_chk("base prog", pcb_pkg::OFS_WIN_BASE, 32'h1234_5800);
    mem_chk(32'h1234_5ffc, 1'b1, 1'b1);
    mem_chk(32'h1234_5800, 1'b1, 1'b1);
    mem_chk(32'h1234_6000, 1'b1, 1'b0);
    mem_chk(32'h1234_5800, 1'b0, 1'b0);
    wr(pcb_pkg::OFS_WIN_BASE, 4'h8, 32'hab00_0000);
    rd_chk("base byte", pcb_pkg::OFS_WIN_BASE, 32'hab34_5800);
    wr_rd_chk("base b2b", pcb_pkg::OFS_WIN_BASE, 32'hffff_ffff,
              32'hffff_f800);
    wr_rd_chk("lat b2b", pcb_pkg::OFS_LAT_LINE, 32'h5a5a_1234,
              32'h0000_1234);
    rd_chk("unmapped", 8'h14, 32'h0000_0000);
    // reset again mid-run: all storage must fall back to its reset values
    @(negedge clock_i);
    rst_n_i = 1'b0;
    repeat (4) @(negedge clock_i);
    rst_n_i = 1'b1;
    rd_chk("lat line rst2", pcb_pkg::OFS_LAT_LINE, 32'h0000_0000);
    rd_chk("base rst2", pcb_pkg::OFS_WIN_BASE, 32'h0000_0000);
    check("line span rst2", 32'h0000_0000, {24'h0, line_span});
    mem_chk(32'h0000_07fc, 1'b1, 1'b1);
    finish_test();
  end
endmodule : tb_top
